// >>> hw/scmc_pkg.sv
// Purpose: shared constants and carrier types for the clock and mode block
// Assumes: one 25 MHz bus clock; oscillator waves are synchronous levels
// Notes:   register offsets are byte addresses of aligned 32-bit words
`default_nettype none

package scmc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_SYSCLK_SEL  = 8'h00;  // system_clock_select
	localparam logic [7:0] ADDR_HS_RC_CTRL  = 8'h04;  // hs_rc_osc_control
	localparam logic [7:0] ADDR_HS_XTL_CTRL = 8'h08;  // hs_crystal_osc_control
	localparam logic [7:0] ADDR_LS_XTL_CTRL = 8'h0C;  // ls_crystal_osc_control

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SEL_FIELD_LSB = 5;   // sysclk_select_field [7:5]
	localparam int SEL_HF_SRC    = 3;   // hf_source_select
	localparam int SEL_LF_SRC    = 2;   // lf_source_select
	localparam int SEL_HF_IDLE   = 1;   // hf_idle_enable
	localparam int SEL_LF_IDLE   = 0;   // lf_idle_enable
	localparam int OSC_MODE_BIT  = 2;   // range / speed-up / freq_sel_lo
	localparam int OSC_FLAG_BIT  = 1;   // stable flag, read only
	localparam int OSC_EN_BIT    = 0;   // oscillator enable
	localparam int RC_FSEL_LSB   = 2;   // fast_rc_freq_sel_hi:lo at [3:2]

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_SYSCLK_SEL  = 8'h00;
	localparam logic [7:0]  RST_HS_RC_CTRL  = 8'h01;  // fast rc on: it clocks the cpu from reset
	localparam logic [7:0]  RST_HS_XTL_CTRL = 8'h00;
	localparam logic [7:0]  RST_LS_XTL_CTRL = 8'h00;
	localparam logic [2:0]  FIELD_UNDIV     = 3'h0;   // high_freq_clock undivided
	localparam logic [2:0]  FIELD_LF        = 3'h7;   // low_freq_clock
	localparam int          DIV_W           = 6;      // divide by up to 64
	localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

	// ------------------------------------------------------------
	// operating modes, one-hot
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		MODE_FAST  = 6'b00_0001,
		MODE_SLOW  = 6'b00_0010,
		MODE_SLEEP = 6'b00_0100,
		MODE_IDLE_LOWSPEED_ONLY = 6'b00_1000,  // idle_lowspeed_only
		MODE_IDLE_BOTH_OSC = 6'b01_0000,  // idle_both_osc
		MODE_IDLE_HIGHSPEED_ONLY = 6'b10_0000   // idle_highspeed_only
	} scmc_mode_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} scmc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} scmc_apb_rsp_t;

	// oscillator waveforms, or their stable flags
	typedef struct packed {
		logic internal_fast_rc_osc;
		logic external_fast_crystal_osc;
		logic internal_slow_rc_osc;
		logic external_slow_crystal_osc;
	} scmc_osc_t;

endpackage : scmc_pkg

`default_nettype wire

// >>> hw/scmc_clk_switch.sv
// Purpose: glitch-free two-way clock waveform selector
// Assumes: both sources are levels sampled on clock
// Notes:   output parks low between sources, so no pulse is cut
`default_nettype none

module scmc_clk_switch (
	// clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// sources and choice
	input  wire logic src_a,
	input  wire logic src_b,
	input  wire logic sel_b,
	// selected waveform
	output logic      clk_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic cur_b;       // source now followed
	logic parked;      // output held low during a change

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic cur_src  = cur_b ? src_b : src_a;   // source in use
	wire logic new_src  = sel_b ? src_b : src_a;   // source asked for
	wire logic want_chg = sel_b != cur_b;

	// park only after the high phase ends, so no pulse is cut short
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cur_b   <= 1'b0;
			parked  <= 1'b0;
			clk_out <= 1'b0;
		end else begin
			if (!parked && want_chg && !cur_src) begin
				parked <= 1'b1;
			end else if (parked && !new_src) begin
				parked <= 1'b0;                      // join new source while it is low
				cur_b  <= sel_b;
			end
			clk_out <= parked ? 1'b0 : cur_src;
		end
	end

endmodule : scmc_clk_switch

`default_nettype wire

// >>> hw/scmc_top.sv
// Purpose: system clock selection, division and operating mode control
// Assumes: halt and wake are one-cycle core pulses; oscillator levels synchronous
// Notes:   clocks leave registered; oscillator start-up is outside
//
// Operation
// - system clock from high or low source
// - high clock: fast rc or fast crystal
// - low clock: slow rc or slow crystal
// - fast mode divides high clock 1 to 64
// - leaving high clock, its enable bit decides
// - six modes: fast, slow, sleep, three idles
// - slow mode runs cpu from low clock
// - halt, both enables low: sleep
// - slow rc clock always runs
// - halt, lf enable only: idle zero
// - halt, both enables: idle one
// - halt, hf enable only: idle two
// - four control registers for clocking
// - field codes: undivided, divided, low clock
// - hf select: 0 rc, 1 crystal
// - lf select: 0 rc, 1 crystal
//
// Implementation choices: the register offsets and the APB interface to the registers.
`default_nettype none

module scmc_top #(
	parameter int DIV_W = scmc_pkg::DIV_W     // divider depth, 6 gives ratio 64
) (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   rstn,
	// register bus
	input  wire scmc_pkg::scmc_apb_req_t apb_req,
	output scmc_pkg::scmc_apb_rsp_t     apb_rsp,
	// oscillator waveforms and stable flags
	input  wire scmc_pkg::scmc_osc_t    osc_wave,
	input  wire scmc_pkg::scmc_osc_t    osc_stable,
	// core events
	input  wire logic                   halt_exec,
	input  wire logic                   wake_event,
	// oscillator enables
	output logic                        fast_rc_on,
	output logic                        fast_crystal_on,
	output logic                        slow_crystal_on,
	output logic                        slow_rc_on,
	// clocks out
	output logic                        cpu_clock,
	output logic                        periph_hf_clock,
	output logic                        periph_lf_clock,
	output logic                        slow_rc_clock,
	// mode status
	output scmc_pkg::scmc_mode_t        op_mode
);

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic [2:0] sysclk_select_field;   // divider / source code
	logic       hf_source_select;      // 0 fast rc, 1 fast crystal
	logic       lf_source_select;      // 0 slow rc, 1 slow crystal
	logic       hf_idle_enable;        // keep high osc in halt
	logic       lf_idle_enable;        // keep low osc in halt
	logic [1:0] fast_rc_freq_sel;      // hi:lo frequency code
	logic       fast_rc_enable;
	logic       fast_crystal_range_mode;
	logic       fast_crystal_enable;
	logic       slow_crystal_speedup;
	logic       slow_crystal_enable;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire logic acc      = apb_req.psel && apb_req.penable;
	wire logic hit_sel  = apb_req.paddr == scmc_pkg::ADDR_SYSCLK_SEL;
	wire logic hit_hrc  = apb_req.paddr == scmc_pkg::ADDR_HS_RC_CTRL;
	wire logic hit_hxl  = apb_req.paddr == scmc_pkg::ADDR_HS_XTL_CTRL;
	wire logic hit_lxl  = apb_req.paddr == scmc_pkg::ADDR_LS_XTL_CTRL;
	wire logic mapped   = hit_sel || hit_hrc || hit_hxl || hit_lxl;
	wire logic wr       = acc && apb_req.pwrite && mapped;
	wire logic [7:0] wd = apb_req.pwdata[7:0];

	// ------------------------------------------------------------
	// mode state
	// ------------------------------------------------------------
	scmc_pkg::scmc_mode_t mode;
	scmc_pkg::scmc_mode_t next_mode;

	wire logic in_fast  = mode == scmc_pkg::MODE_FAST;
	wire logic in_slow  = mode == scmc_pkg::MODE_SLOW;
	wire logic in_idle_lowspeed_only = mode == scmc_pkg::MODE_IDLE_LOWSPEED_ONLY;
	wire logic in_idle_both_osc = mode == scmc_pkg::MODE_IDLE_BOTH_OSC;
	wire logic in_idle_highspeed_only = mode == scmc_pkg::MODE_IDLE_HIGHSPEED_ONLY;
	wire logic running  = in_fast || in_slow;
	wire logic lf_chosen = sysclk_select_field == scmc_pkg::FIELD_LF;

	// slow crystal speed-up frozen while it clocks the system
	wire logic lxtl_is_sys = lf_chosen && lf_source_select;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// reserved bits not stored; stable flags are live inputs
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sysclk_select_field     <= scmc_pkg::RST_SYSCLK_SEL[7:5];
			hf_source_select        <= scmc_pkg::RST_SYSCLK_SEL[scmc_pkg::SEL_HF_SRC];
			lf_source_select        <= scmc_pkg::RST_SYSCLK_SEL[scmc_pkg::SEL_LF_SRC];
			hf_idle_enable          <= scmc_pkg::RST_SYSCLK_SEL[scmc_pkg::SEL_HF_IDLE];
			lf_idle_enable          <= scmc_pkg::RST_SYSCLK_SEL[scmc_pkg::SEL_LF_IDLE];
			fast_rc_freq_sel        <= scmc_pkg::RST_HS_RC_CTRL[3:2];
			fast_rc_enable          <= scmc_pkg::RST_HS_RC_CTRL[scmc_pkg::OSC_EN_BIT];
			fast_crystal_range_mode <= scmc_pkg::RST_HS_XTL_CTRL[scmc_pkg::OSC_MODE_BIT];
			fast_crystal_enable     <= scmc_pkg::RST_HS_XTL_CTRL[scmc_pkg::OSC_EN_BIT];
			slow_crystal_speedup    <= scmc_pkg::RST_LS_XTL_CTRL[scmc_pkg::OSC_MODE_BIT];
			slow_crystal_enable     <= scmc_pkg::RST_LS_XTL_CTRL[scmc_pkg::OSC_EN_BIT];
		end else if (wr) begin
			if (hit_sel) begin
				sysclk_select_field <= wd[scmc_pkg::SEL_FIELD_LSB +: 3];
				hf_source_select    <= wd[scmc_pkg::SEL_HF_SRC];
				lf_source_select    <= wd[scmc_pkg::SEL_LF_SRC];
				hf_idle_enable      <= wd[scmc_pkg::SEL_HF_IDLE];
				lf_idle_enable      <= wd[scmc_pkg::SEL_LF_IDLE];
			end
			if (hit_hrc) begin
				fast_rc_freq_sel <= wd[scmc_pkg::RC_FSEL_LSB +: 2];
				fast_rc_enable   <= wd[scmc_pkg::OSC_EN_BIT];
			end
			if (hit_hxl) begin
				fast_crystal_range_mode <= wd[scmc_pkg::OSC_MODE_BIT];
				fast_crystal_enable     <= wd[scmc_pkg::OSC_EN_BIT];
			end
			if (hit_lxl) begin
				if (!lxtl_is_sys) begin
					slow_crystal_speedup <= wd[scmc_pkg::OSC_MODE_BIT];
				end
				slow_crystal_enable <= wd[scmc_pkg::OSC_EN_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire logic [7:0] rd_sel = {sysclk_select_field, 1'b0, hf_source_select, lf_source_select,
		hf_idle_enable, lf_idle_enable};
	wire logic [7:0] rd_hrc = {4'h0, fast_rc_freq_sel, osc_stable.internal_fast_rc_osc, fast_rc_enable};
	wire logic [7:0] rd_hxl = {5'h00, fast_crystal_range_mode, osc_stable.external_fast_crystal_osc,
		fast_crystal_enable};
	wire logic [7:0] rd_lxl = {5'h00, slow_crystal_speedup, osc_stable.external_slow_crystal_osc,
		slow_crystal_enable};
	wire logic [7:0] rd_byte = hit_sel ? rd_sel :
		hit_hrc ? rd_hrc :
		hit_hxl ? rd_hxl :
		hit_lxl ? rd_lxl : 8'h00;

	// zero-wait slave; read data registered at setup
	logic [31:0] rdata_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= scmc_pkg::RDATA_ZERO;
		end else if (apb_req.psel && !apb_req.penable) begin
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	assign apb_rsp.prdata  = rdata_q;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = acc && !mapped;   // unmapped addresses answer with an error

	// ------------------------------------------------------------
	// operating mode machine
	// ------------------------------------------------------------
	// enables read in the halt cycle; later writes cannot change the mode
	always_comb begin
		next_mode = mode;
		unique case (1'b1)
			in_fast, in_slow: begin
				if (halt_exec) begin
					unique case ({hf_idle_enable, lf_idle_enable})
						2'b00: next_mode = scmc_pkg::MODE_SLEEP;
						2'b01: next_mode = scmc_pkg::MODE_IDLE_LOWSPEED_ONLY;
						2'b11: next_mode = scmc_pkg::MODE_IDLE_BOTH_OSC;
						2'b10: next_mode = scmc_pkg::MODE_IDLE_HIGHSPEED_ONLY;
					endcase
				end else begin
					next_mode = lf_chosen ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST;
				end
			end
			default: begin
				// wake returns to the running mode the field names
				if (wake_event) begin
					next_mode = lf_chosen ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode <= scmc_pkg::MODE_FAST;
		end else begin
			mode <= next_mode;
		end
	end

	assign op_mode = mode;

	// ------------------------------------------------------------
	// oscillator enables
	// ------------------------------------------------------------
	// high osc kept while it clocks the system or a halt mode asks for it
	wire logic hf_keep = in_fast || in_idle_both_osc || in_idle_highspeed_only;
	wire logic lf_keep = running || in_idle_lowspeed_only || in_idle_both_osc;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fast_rc_on      <= 1'b1;
			fast_crystal_on <= 1'b0;
			slow_crystal_on <= 1'b0;
			slow_rc_on      <= 1'b1;
		end else begin
			fast_rc_on      <= (hf_keep && !hf_source_select) || (running && fast_rc_enable);
			fast_crystal_on <= (hf_keep && hf_source_select) || (running && fast_crystal_enable);
			slow_crystal_on <= (lf_keep && lf_source_select) || (running && slow_crystal_enable);
			slow_rc_on      <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// source selection
	// ------------------------------------------------------------
	logic high_freq_clock;
	logic low_freq_clock;

	scmc_clk_switch u_hf_sw (
		.clock   (clock),
		.rstn    (rstn),
		.src_a   (osc_wave.internal_fast_rc_osc),
		.src_b   (osc_wave.external_fast_crystal_osc),
		.sel_b   (hf_source_select),
		.clk_out (high_freq_clock)
	);

	scmc_clk_switch u_lf_sw (
		.clock   (clock),
		.rstn    (rstn),
		.src_a   (osc_wave.internal_slow_rc_osc),
		.src_b   (osc_wave.external_slow_crystal_osc),
		.sel_b   (lf_source_select),
		.clk_out (low_freq_clock)
	);

	// ------------------------------------------------------------
	// high clock divider
	// ------------------------------------------------------------
	logic             hf_prev;
	logic [DIV_W-1:0] div_cnt;
	wire logic        hf_rise = high_freq_clock && !hf_prev;

	// counter bit k is the high clock over 2^(k+1)
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hf_prev <= 1'b0;
			div_cnt <= '0;
		end else begin
			hf_prev <= high_freq_clock;
			if (hf_rise) begin
				div_cnt <= div_cnt + 1'b1;
			end
		end
	end

	// tap for a field code: 0 undivided, k divides by 2^k
	function automatic logic div_tap(input logic [2:0] code, input logic hf, input logic [DIV_W-1:0] cnt);
		logic t;
		t = hf;
		if (code != scmc_pkg::FIELD_UNDIV && code != scmc_pkg::FIELD_LF) begin
			t = cnt[code - 3'h1];
		end
		return t;
	endfunction : div_tap

	// ratio changes only while old and new taps are low
	logic [2:0] div_code;
	wire logic  tap_now = div_tap(div_code, high_freq_clock, div_cnt);
	wire logic  tap_new = div_tap(sysclk_select_field, high_freq_clock, div_cnt);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div_code <= scmc_pkg::FIELD_UNDIV;
		end else if (!lf_chosen && div_code != sysclk_select_field && !tap_now && !tap_new) begin
			div_code <= sysclk_select_field;
		end
	end

	// ------------------------------------------------------------
	// system clock choice
	// ------------------------------------------------------------
	logic sys_clock;

	scmc_clk_switch u_sys_sw (
		.clock   (clock),
		.rstn    (rstn),
		.src_a   (tap_now),
		.src_b   (low_freq_clock),
		.sel_b   (lf_chosen),
		.clk_out (sys_clock)
	);

	// ------------------------------------------------------------
	// clock gates
	// ------------------------------------------------------------
	// enables move only while the source is low: no cut pulse
	localparam int NGATE = 3;
	logic [NGATE-1:0] gate_src;
	logic [NGATE-1:0] gate_want;
	logic [NGATE-1:0] gate_en;
	logic [NGATE-1:0] gate_out;

	wire logic hf_sel_en = hf_source_select ? fast_crystal_enable : fast_rc_enable;

	assign gate_src  = {low_freq_clock, high_freq_clock, sys_clock};
	assign gate_want = {
		lf_keep,
		hf_keep || (in_slow && hf_sel_en),
		running
	};

	genvar g;
	generate
		for (g = 0; g < NGATE; g++) begin : g_gate
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					gate_en[g]  <= 1'b0;
					gate_out[g] <= 1'b0;
				end else begin
					if (!gate_src[g]) begin
						gate_en[g] <= gate_want[g];
					end
					gate_out[g] <= gate_src[g] && gate_en[g];
				end
			end
		end
	endgenerate

	assign cpu_clock       = gate_out[0];
	assign periph_hf_clock = gate_out[1];
	assign periph_lf_clock = gate_out[2];

	// ------------------------------------------------------------
	// watchdog clock
	// ------------------------------------------------------------
	// runs in every mode, sleep included, for the watchdog
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			slow_rc_clock <= 1'b0;
		end else begin
			slow_rc_clock <= osc_wave.internal_slow_rc_osc;
		end
	end

endmodule : scmc_top

`default_nettype wire

// >>> test/scmc_top_checker.sv
// Purpose: concurrent checks on the ports of the clock and mode block
// Assumes: selection register changes only by bus writes
// Notes:   idle checks wait a cycle: enables are registered
`default_nettype none

module scmc_top_checker (
	// clock and reset
	input wire logic                    clock,
	input wire logic                    rstn,
	// bus and core events
	input wire scmc_pkg::scmc_apb_req_t apb_req,
	input wire scmc_pkg::scmc_apb_rsp_t apb_rsp,
	input wire logic                    halt_exec,
	input wire logic                    wake_event,
	input wire scmc_pkg::scmc_osc_t     osc_wave,
	// enables, clock, mode
	input wire logic                    fast_rc_on,
	input wire logic                    fast_crystal_on,
	input wire logic                    slow_crystal_on,
	input wire logic                    slow_rc_on,
	input wire logic                    slow_rc_clock,
	input wire scmc_pkg::scmc_mode_t    op_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	logic [7:0] sel_shadow;  // copy of the selection register
	logic       running;     // cpu clocked
	logic       mapped;      // one of the four words
	logic [5:0] halt_pick;   // mode a halt would choose now
	assign running   = op_mode == scmc_pkg::MODE_FAST || op_mode == scmc_pkg::MODE_SLOW;
	assign mapped    = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr < 8'h10;
	assign halt_pick = sel_shadow[1] ? (sel_shadow[0] ? scmc_pkg::MODE_IDLE_BOTH_OSC : scmc_pkg::MODE_IDLE_HIGHSPEED_ONLY) :
		(sel_shadow[0] ? scmc_pkg::MODE_IDLE_LOWSPEED_ONLY : scmc_pkg::MODE_SLEEP);
	// shadow follows completed writes only
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sel_shadow <= scmc_pkg::RST_SYSCLK_SEL;
		end else if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == scmc_pkg::ADDR_SYSCLK_SEL) begin
			sel_shadow <= apb_req.pwdata[7:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_halt_taken;
		halt_exec && running;
	endsequence
	sequence s_wake_taken;
		wake_event && !running;
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_pready_high: assert property (apb_rsp.pready)
		else $error("pready low");
	a_unmapped_err: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pslverr == !mapped)
		else $error("slave error does not match address");
	a_halt_mode: assert property (s_halt_taken |=> op_mode == $past(halt_pick))
		else $error("halt chose wrong mode");
	a_wake_run: assert property (s_wake_taken |=> op_mode == ($past(sel_shadow[7:5]) == 3'h7 ?
		scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST))
		else $error("wake chose wrong mode");
	a_mode_onehot: assert property ($onehot(op_mode))
		else $error("mode not one-hot");
	a_slow_rc_run: assert property ($past(rstn) |-> slow_rc_on && slow_rc_clock == $past(osc_wave.internal_slow_rc_osc))
		else $error("slow rc clock stopped");
	a_sleep_off: assert property ((op_mode == scmc_pkg::MODE_SLEEP)[*2] |-> !fast_rc_on && !fast_crystal_on && !slow_crystal_on)
		else $error("oscillator left on in sleep");
	a_idle_hf: assert property ((op_mode == scmc_pkg::MODE_IDLE_BOTH_OSC || op_mode == scmc_pkg::MODE_IDLE_HIGHSPEED_ONLY)[*2]
		|-> (sel_shadow[3] ? fast_crystal_on : fast_rc_on))
		else $error("high oscillator off in idle");
	a_idle_lowspeed_only_lf: assert property ((op_mode == scmc_pkg::MODE_IDLE_LOWSPEED_ONLY)[*2]
		|-> !fast_rc_on && !fast_crystal_on && (slow_crystal_on == sel_shadow[2]))
		else $error("idle zero oscillators wrong");
	a_idle_highspeed_only_lf: assert property ((op_mode == scmc_pkg::MODE_IDLE_HIGHSPEED_ONLY)[*2] |-> !slow_crystal_on)
		else $error("slow crystal on in idle two");
endmodule : scmc_top_checker

bind scmc_top scmc_top_checker u_chk (.clock(clock), .rstn(rstn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .halt_exec(halt_exec), .wake_event(wake_event), .osc_wave(osc_wave),
	.fast_rc_on(fast_rc_on), .fast_crystal_on(fast_crystal_on), .slow_crystal_on(slow_crystal_on),
	.slow_rc_on(slow_rc_on), .slow_rc_clock(slow_rc_clock), .op_mode(op_mode));

`default_nettype wire

// >>> test/scmc_core_model.sv
// Purpose: behavioural cpu core that issues halt and wake and times its clock
// Assumes: requests are one-cycle pulses from the bench
// Notes:   period is bus clock cycles between cpu clock rises
`default_nettype none

module scmc_core_model (
	// clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// bench requests and the clock consumed
	input  wire logic halt_req,
	input  wire logic wake_req,
	input  wire logic cpu_clock,
	// core events and measurement
	output logic      halt_exec,
	output logic      wake_event,
	output int        cpu_period
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_clk;  // cpu clock one cycle ago
	int   cnt;       // cycles since last rise
	// events leave one cycle after the request
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			halt_exec  <= 1'b0;
			wake_event <= 1'b0;
			last_clk   <= 1'b0;
			cnt        <= 0;
			cpu_period <= 0;
		end else begin
			halt_exec  <= halt_req;
			wake_event <= wake_req;
			last_clk   <= cpu_clock;
			cnt        <= cnt + 1;
			if (cpu_clock && !last_clk) begin
				cpu_period <= cnt + 1;
				cnt        <= 0;
			end
		end
	end
endmodule : scmc_core_model

`default_nettype wire

// >>> test/system_clock_mode_control_tb.sv
// Purpose: self-checking bench for clock selection, division and modes
// Assumes: oscillators are square waves of 2, 4, 8 and 16 cycles
// Notes:   register model keeps masked values; stable flags are random levels
`default_nettype none

module system_clock_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// signals and model
	// ------------------------------------------------------------
	logic                    clock, rstn, halt_req, wake_req, halt_exec, wake_event, er;
	logic                    fast_rc_on, fast_crystal_on, slow_crystal_on, slow_rc_on;
	logic                    cpu_clock, periph_hf_clock, periph_lf_clock, slow_rc_clock;
	scmc_pkg::scmc_apb_req_t apb_req;
	scmc_pkg::scmc_apb_rsp_t apb_rsp;
	scmc_pkg::scmc_osc_t     osc_wave, osc_stable;
	scmc_pkg::scmc_mode_t    op_mode;
	logic [3:0]              wave_cnt;   // source of all oscillator waves
	logic [31:0]             rd;
	int                      cpu_period, err_count, n_tests, seed;
	logic [7:0]              mdl [4];    // expected register contents
	localparam logic [7:0] MASK [4] = '{8'hEF, 8'h0D, 8'h05, 8'h05};
	localparam logic [5:0] HALT_MODE [4] = '{6'h04, 6'h08, 6'h20, 6'h10};  // by {hf,lf} idle enables

	scmc_top dut (.clock(clock), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp), .osc_wave(osc_wave),
		.osc_stable(osc_stable), .halt_exec(halt_exec), .wake_event(wake_event), .fast_rc_on(fast_rc_on),
		.fast_crystal_on(fast_crystal_on), .slow_crystal_on(slow_crystal_on), .slow_rc_on(slow_rc_on),
		.cpu_clock(cpu_clock), .periph_hf_clock(periph_hf_clock), .periph_lf_clock(periph_lf_clock),
		.slow_rc_clock(slow_rc_clock), .op_mode(op_mode));
	scmc_core_model core (.clock(clock), .rstn(rstn), .halt_req(halt_req), .wake_req(wake_req),
		.cpu_clock(cpu_clock), .halt_exec(halt_exec), .wake_event(wake_event), .cpu_period(cpu_period));

	always #20 clock = ~clock;
	always @(posedge clock) wave_cnt <= wave_cnt + 4'h1;
	assign osc_wave = {wave_cnt[0], wave_cnt[1], wave_cnt[2], wave_cnt[3]};
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk
	// request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clock);
		apb_req.penable <= 1'b1;
		do @(posedge clock); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : apb
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a == 8'h0C && (mdl[0] & 8'hE4) == 8'hE4) d[2] = mdl[3][2];  // speed-up locked
		mdl[a[3:2]] = d[7:0] & MASK[a[3:2]];
	endtask : wreg
	task automatic rreg(input logic [7:0] a);
		logic [3:0] f;
		f = {1'b0, osc_stable.external_slow_crystal_osc, osc_stable.external_fast_crystal_osc,
			osc_stable.internal_fast_rc_osc};
		apb(1'b0, a, 32'h0000_0000);
		chk("register", {24'h0, mdl[a[3:2]] | (a[3:2] != 2'h0 ? {6'h0, f[a[3:2] - 2'h1], 1'b0} : 8'h00)}, rd);
	endtask : rreg
	task automatic core_evt(input logic h);
		@(posedge clock);
		halt_req <= h;
		wake_req <= !h;
		@(posedge clock);
		halt_req <= 1'b0;
		wake_req <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : core_evt
	task automatic per(input logic [7:0] system_clock_select, input int exp);
		wreg(8'h00, {24'h0, system_clock_select});
		repeat (400) @(posedge clock);
		chk("cpu period", exp, cpu_period);
	endtask : per
	task automatic wrap_up;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// ------------------------------------------------------------
	// sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		#(40 * 20000);
		err_count++;
		wrap_up();
	end
	initial begin
		clock = 0; rstn = 0; halt_req = 0; wake_req = 0; wave_cnt = 4'h0; apb_req = '0;
		err_count = 0; n_tests = 0; seed = 41; mdl = '{8'h00, 8'h01, 8'h00, 8'h00};
		osc_stable = 4'($random(seed));
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++) rreg(8'(i * 4));
		for (int i = 1; i < 4; i++) begin
			wreg(8'(i * 4), $random(seed));
			rreg(8'(i * 4));
		end
		wreg(8'h00, 32'h0000_00FF);
		rreg(8'h00);
		wreg(8'h0C, {24'h0, ~mdl[3]});
		rreg(8'h0C);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		for (int c = 0; c < 4; c++) begin
			wreg(8'h00, {24'h0, 8'(c) | (8'($random(seed)) & 8'h08)});
			core_evt(1'b1);
			chk("halt mode", {26'h0, HALT_MODE[c]}, {26'h0, op_mode});
			core_evt(1'b0);
			chk("wake mode", 32'h1, {26'h0, op_mode});
		end
		wreg(8'h00, 32'h0000_00E0);
		core_evt(1'b1);
		core_evt(1'b0);
		chk("slow wake mode", 32'h2, {26'h0, op_mode});
		for (int k = 0; k < 7; k++) per(8'(k << 5), 2 << k);
		per(8'h08, 4);
		per(8'hE0, 8);
		per(8'hE4, 16);
		wrap_up();
	end
endmodule : system_clock_mode_control_tb

`default_nettype wire
